/* src/tx_status_pkg.sv */
// Purpose: constants and types for the transmit queue status block
// Assumes: single clock CLK at 100 MHz, synchronous active-high RST
// Notes: register offsets are byte addresses on the plain register port
package tx_status_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam logic [7:0] OFF_TRANSMIT_STATUS = 8'h02;
  localparam logic [7:0] OFF_CONTROL = 8'h10;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h11;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h12;
  localparam logic [7:0] OFF_RX_STATUS = 8'h13;
  // transmit status bit positions
  localparam int BIT_HELD = 7;
  localparam int BIT_BUSY = 5;
  localparam int BIT_IDLE = 4;
  localparam int BIT_OVF = 3;
  localparam int BIT_FULL = 2;
  localparam int BIT_AVAIL = 1;
  localparam int BIT_EMPTY = 0;
  localparam logic [7:0] RESET_TRANSMIT_STATUS = 8'h13;
  // interrupt event bit positions
  localparam int EV_HELD = 0;
  localparam int EV_FULL = 1;
  localparam int EV_EMPTY = 2;
  localparam int EV_RX_OVF = 3;
  localparam int EV_TX_OVF = 4;
  localparam int EV_W = 5;
  localparam logic [7:0] BUS_DEFAULT = 8'h00;
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } bus_req_t;
  typedef struct packed {
    logic held;
    logic busy;
    logic idle;
    logic tx_ovf;
    logic full;
    logic avail;
    logic empty;
  } tx_flags_t;
endpackage : tx_status_pkg

/* src/tx_flag_logic.sv */
// Purpose: combinational queue flag decode from pointers and buffer space
// Assumes: pointers count queues modulo 2**QW
// Notes: pure logic, registered by the parent
module tx_flag_logic #(
  parameter int QW = 3,
  parameter int LW = 9
) (
  input wire logic [QW-1:0] load_queue_pointer,
  input wire logic [QW-1:0] send_queue_pointer,
  input wire logic [LW-1:0] rx_free_bytes,
  input wire logic [LW-1:0] message_length,
  input wire logic ignore_receive_space,
  output logic held,
  output logic full,
  output logic avail,
  output logic empty
);
  logic [LW:0] need;
  // one extra bit so length plus one never wraps
  always_comb
  begin
    need = {1'b0, message_length} + {{LW{1'b0}}, 1'b1};
    held = !ignore_receive_space &&
      ({1'b0, rx_free_bytes} < need);
    full = (load_queue_pointer ==
      QW'(send_queue_pointer - QW'(1)));
    avail = !full;
    empty = (load_queue_pointer == send_queue_pointer);
  end
endmodule : tx_flag_logic

/* src/uart_transmit_queue_status.sv */
// Purpose: transmit status register, start gating and event interrupts
// Assumes: queue pointers, counts and strobes come from logic on CLK
// Notes: reads of the register port return data one cycle after RD
module uart_transmit_queue_status #(
  parameter int QW = 3,
  parameter int LW = 9
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic [tx_status_pkg::ADDR_W-1:0] ADDR,
  input wire logic [tx_status_pkg::DATA_W-1:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [tx_status_pkg::DATA_W-1:0] RDATA,
  input wire logic [QW-1:0] LOAD_QUEUE_POINTER,
  input wire logic [QW-1:0] SEND_QUEUE_POINTER,
  input wire logic [LW-1:0] RX_FREE_BYTES,
  input wire logic [LW-1:0] MESSAGE_LENGTH,
  input wire logic RX_BYTE_WRITE,
  input wire logic TX_INCREMENT_BLOCKED,
  input wire logic START_REQUEST,
  input wire logic TX_SENDING,
  output logic START_GRANT,
  output logic IGNORE_RECEIVE_SPACE,
  output logic RECEIVE_OVERFLOW_ERROR,
  output logic IRQ
);
  tx_status_pkg::bus_req_t req;
  tx_status_pkg::tx_flags_t flags;
  logic held_c, full_c, avail_c, empty_c;
  logic [tx_status_pkg::EV_W-1:0] irq_status, irq_mask, events;
  logic [tx_status_pkg::EV_W-1:0] next_irq_status;
  logic held_q, full_q, empty_q;
  logic [7:0] status_byte;
  logic ctrl_write, irq_clear_write, mask_write;
  logic rx_full;
  // reset image of the status byte, one bit per flag
  localparam logic [7:0] reset_byte = tx_status_pkg::RESET_TRANSMIT_STATUS;

  assign req = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};

  // one-cycle write strobe aimed at one register offset
  function automatic logic write_hit(
    input tx_status_pkg::bus_req_t r,
    input logic [tx_status_pkg::ADDR_W-1:0] off
  );
    return r.wr && (r.addr == off);
  endfunction : write_hit

  // decoded write strobes, one per writable register
  assign ctrl_write = write_hit(req, tx_status_pkg::OFF_CONTROL);
  assign irq_clear_write = write_hit(req, tx_status_pkg::OFF_IRQ_STATUS);
  assign mask_write = write_hit(req, tx_status_pkg::OFF_IRQ_MASK);

  // a full receive buffer means the next written byte overwrites data
  assign rx_full = (RX_FREE_BYTES == '0);

  tx_flag_logic #(.QW(QW), .LW(LW)) u_flags (
    .load_queue_pointer(LOAD_QUEUE_POINTER),
    .send_queue_pointer(SEND_QUEUE_POINTER),
    .rx_free_bytes(RX_FREE_BYTES),
    .message_length(MESSAGE_LENGTH),
    .ignore_receive_space(IGNORE_RECEIVE_SPACE),
    .held(held_c),
    .full(full_c),
    .avail(avail_c),
    .empty(empty_c)
  );

  // registered flags; reset values match the status reset byte
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      // quiet line, no queued data: idle, available and empty set
      flags.held <= reset_byte[tx_status_pkg::BIT_HELD];
      flags.busy <= reset_byte[tx_status_pkg::BIT_BUSY];
      flags.idle <= reset_byte[tx_status_pkg::BIT_IDLE];
      flags.tx_ovf <= reset_byte[tx_status_pkg::BIT_OVF];
      flags.full <= reset_byte[tx_status_pkg::BIT_FULL];
      flags.avail <= reset_byte[tx_status_pkg::BIT_AVAIL];
      flags.empty <= reset_byte[tx_status_pkg::BIT_EMPTY];
    end
    else
    begin
      flags.held <= held_c;
      flags.full <= full_c;
      flags.avail <= avail_c;
      flags.empty <= empty_c;
      flags.busy <= TX_SENDING;
      flags.idle <= !TX_SENDING;
      flags.tx_ovf <= TX_INCREMENT_BLOCKED && !empty_c;
    end
  end

  // start gate uses live held term so a grant never beats a late length
  always_ff @(posedge CLK)
  begin
    if (RST)
      START_GRANT <= 1'b0;
    else
      START_GRANT <= START_REQUEST && !held_c;
  end

  // overflow: a write into a full receive buffer overwrites a byte;
  // the flag clears as soon as free space returns
  always_ff @(posedge CLK)
  begin
    if (RST)
      RECEIVE_OVERFLOW_ERROR <= 1'b0;
    else if (!rx_full)
      RECEIVE_OVERFLOW_ERROR <= 1'b0;
    else if (RX_BYTE_WRITE)
      RECEIVE_OVERFLOW_ERROR <= 1'b1;
  end

  // control register: only the ignore option, bit 0
  always_ff @(posedge CLK)
  begin
    if (RST)
      IGNORE_RECEIVE_SPACE <= 1'b0;
    else if (ctrl_write)
      IGNORE_RECEIVE_SPACE <= req.wdata[0];
  end

  // rising edges of held, full and empty are interrupt events; host relies on the
  // overflow event when running without the space check
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      held_q <= reset_byte[tx_status_pkg::BIT_HELD];
      full_q <= reset_byte[tx_status_pkg::BIT_FULL];
      empty_q <= reset_byte[tx_status_pkg::BIT_EMPTY];
    end
    else
    begin
      held_q <= flags.held;
      full_q <= flags.full;
      empty_q <= flags.empty;
    end
  end

  // edges come from the registered flags, so an event lags the flag inputs
  // by one cycle; the overflow events are taken straight from inputs
  always_comb
  begin
    events = '0;
    events[tx_status_pkg::EV_HELD] = flags.held && !held_q;
    events[tx_status_pkg::EV_FULL] = flags.full && !full_q;
    events[tx_status_pkg::EV_EMPTY] = flags.empty && !empty_q;
    events[tx_status_pkg::EV_RX_OVF] = RX_BYTE_WRITE && rx_full;
    events[tx_status_pkg::EV_TX_OVF] = TX_INCREMENT_BLOCKED;
    // write-one-to-clear, but a new event in the same cycle wins
    next_irq_status = irq_status;
    if (irq_clear_write)
      next_irq_status = irq_status &
        ~req.wdata[tx_status_pkg::EV_W-1:0];
    next_irq_status = next_irq_status | events;
  end

  // sticky event bits
  always_ff @(posedge CLK)
  begin
    if (RST)
      irq_status <= '0;
    else
      irq_status <= next_irq_status;
  end

  // mask bits share the layout of the event bits
  always_ff @(posedge CLK)
  begin
    if (RST)
      irq_mask <= '0;
    else if (mask_write)
      irq_mask <= req.wdata[tx_status_pkg::EV_W-1:0];
  end

  // level interrupt, registered so it comes straight from a flop
  always_ff @(posedge CLK)
  begin
    if (RST)
      IRQ <= 1'b0;
    else
      IRQ <= |(next_irq_status & irq_mask);
  end

  // status byte assembly; bit 6 is unused and reads as zero
  always_comb
  begin
    status_byte = 8'h00;
    status_byte[tx_status_pkg::BIT_HELD] = flags.held;
    status_byte[tx_status_pkg::BIT_BUSY] = flags.busy;
    status_byte[tx_status_pkg::BIT_IDLE] = flags.idle;
    status_byte[tx_status_pkg::BIT_OVF] = flags.tx_ovf;
    status_byte[tx_status_pkg::BIT_FULL] = flags.full;
    status_byte[tx_status_pkg::BIT_AVAIL] = flags.avail;
    status_byte[tx_status_pkg::BIT_EMPTY] = flags.empty;
  end

  // read data stands only in the cycle after the read strobe;
  // unmapped addresses read as zero
  always_ff @(posedge CLK)
  begin
    if (RST)
      RDATA <= tx_status_pkg::BUS_DEFAULT;
    else if (!req.rd)
      RDATA <= tx_status_pkg::BUS_DEFAULT;
    else
      unique case (req.addr)
        tx_status_pkg::OFF_TRANSMIT_STATUS: RDATA <= status_byte;
        tx_status_pkg::OFF_CONTROL:
          RDATA <= {7'h00, IGNORE_RECEIVE_SPACE};
        tx_status_pkg::OFF_IRQ_STATUS: RDATA <= {3'h0, irq_status};
        tx_status_pkg::OFF_IRQ_MASK: RDATA <= {3'h0, irq_mask};
        tx_status_pkg::OFF_RX_STATUS:
          RDATA <= {7'h00, RECEIVE_OVERFLOW_ERROR};
        default: RDATA <= tx_status_pkg::BUS_DEFAULT;
      endcase
  end
endmodule : uart_transmit_queue_status

/* bench/uart_transmit_queue_status_checker.sv */
// Purpose: port checks of transmit status flags and start gating
// Assumes: status reads are judged only while flag inputs hold still
// Notes: bound to every instance of the status block
module uart_transmit_queue_status_checker #(
  parameter int QW = 3,
  parameter int LW = 9
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic [7:0] ADDR,
  input wire logic RD,
  input wire logic [7:0] RDATA,
  input wire logic [QW-1:0] LOAD_QUEUE_POINTER,
  input wire logic [QW-1:0] SEND_QUEUE_POINTER,
  input wire logic [LW-1:0] RX_FREE_BYTES,
  input wire logic [LW-1:0] MESSAGE_LENGTH,
  input wire logic RX_BYTE_WRITE,
  input wire logic START_REQUEST,
  input wire logic TX_SENDING,
  input wire logic START_GRANT,
  input wire logic IGNORE_RECEIVE_SPACE,
  input wire logic RECEIVE_OVERFLOW_ERROR,
  input wire logic IRQ
);
  localparam int TOP = 2*QW+2*LW+2;
  logic [TOP:0] prev, now;
  logic calm, held, full, empty, st;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  // a moving input would make the one-cycle flag lag ambiguous
  assign now = {RST, IGNORE_RECEIVE_SPACE, TX_SENDING, LOAD_QUEUE_POINTER,
    SEND_QUEUE_POINTER, RX_FREE_BYTES, MESSAGE_LENGTH};
  always_ff @(posedge CLK) prev <= now;
  // free <= length is free < length + 1 without any wrap
  assign calm = prev == now && !prev[TOP];
  assign held = !IGNORE_RECEIVE_SPACE && (RX_FREE_BYTES <= MESSAGE_LENGTH);
  assign full = LOAD_QUEUE_POINTER == SEND_QUEUE_POINTER - 1'b1;
  assign empty = LOAD_QUEUE_POINTER == SEND_QUEUE_POINTER;
  assign st = RD && ADDR == tx_status_pkg::OFF_TRANSMIT_STATUS && calm;
  chk_held_bit: assert property
    (st |=> RDATA[7] == $past(held)) else $error("held flag wrong");
  chk_full_avail: assert property
    (st |=> RDATA[2] == $past(full) && RDATA[1] == !RDATA[2])
    else $error("full or avail flag wrong");
  chk_empty_bit: assert property
    (st |=> RDATA[0] == $past(empty)) else $error("empty flag wrong");
  chk_busy_idle: assert property
    (st |=> RDATA[5] == $past(TX_SENDING) && RDATA[4] != RDATA[5])
    else $error("busy or idle flag wrong");
  chk_start_held: assert property
    (START_REQUEST && held |=> !START_GRANT) else $error("start not held");
  chk_start_open: assert property
    (START_REQUEST && !held |=> START_GRANT) else $error("start not given");
  chk_ovf_set: assert property
    (RX_BYTE_WRITE && RX_FREE_BYTES == '0 |=> RECEIVE_OVERFLOW_ERROR)
    else $error("overflow not flagged");
  chk_ovf_clear: assert property
    (RX_FREE_BYTES != '0 |=> !RECEIVE_OVERFLOW_ERROR)
    else $error("overflow not cleared");
  cover property (st && held);
  cover property (START_REQUEST && !held ##1 START_GRANT);
  cover property (RECEIVE_OVERFLOW_ERROR && IRQ);
endmodule : uart_transmit_queue_status_checker
bind uart_transmit_queue_status uart_transmit_queue_status_checker
  #(.QW(QW), .LW(LW)) chk_i (.*);

/* bench/uart_engine_model.sv */
// Purpose: far-side transmit engine that asks to start, then sends
// Assumes: one CLK domain, synchronous RST
// Notes: a granted message keeps the line busy for four cycles
module uart_engine_model (
  input wire logic CLK,
  input wire logic RST,
  input wire logic go,
  input wire logic grant,
  output logic req,
  output logic sending
);
  logic [2:0] left;
  // request stands until granted; the line stays quiet before that
  always_ff @(posedge CLK)
  begin
    req <= !RST && (go || (req && !grant));
    left <= RST ? 3'h0 : (req && grant) ? 3'h4 : left - 3'(sending);
  end
  assign sending = left != 3'h0;
endmodule : uart_engine_model

/* bench/uart_transmit_queue_status_bench.sv */
// Purpose: register-level test of transmit flags and start gating
// Assumes: engine model supplies start request and line activity
// Notes: flag inputs are held still around every status read
module uart_transmit_queue_status_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic CLK, RST, WR, RD, RX_BYTE_WRITE, TX_INCREMENT_BLOCKED, go;
  logic START_REQUEST, TX_SENDING, START_GRANT, IGNORE_RECEIVE_SPACE;
  logic RECEIVE_OVERFLOW_ERROR, IRQ;
  logic [7:0] ADDR, WDATA, RDATA;
  logic [2:0] LOAD_QUEUE_POINTER, SEND_QUEUE_POINTER;
  logic [8:0] RX_FREE_BYTES, MESSAGE_LENGTH;
  int fails, n_checks;
  uart_transmit_queue_status uart_transmit_queue_status_i (.*);
  uart_engine_model uart_engine_model_i (.CLK, .RST, .go,
    .grant(START_GRANT), .req(START_REQUEST), .sending(TX_SENDING));
  // free-running 100 MHz clock
  initial
  begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end
  task automatic chk(input string n, input logic [7:0] e, s);
    n_checks++;
    if (s !== e)
    begin
      $display("MISMATCH %s expected %h seen %h", n, e, s);
      fails++;
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, d);
    @(posedge CLK);
    {ADDR, WDATA, WR} <= {a, d, 1'b1};
    @(posedge CLK);
    WR <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [7:0] a, e);
    @(posedge CLK);
    {ADDR, RD} <= {a, 1'b1};
    @(posedge CLK);
    RD <= 1'b0;
    #1 chk("rdata", e, RDATA);
  endtask : rd
  task automatic set(input logic [2:0] l, s, input logic [8:0] f, m,
    input logic b);
    @(posedge CLK);
    LOAD_QUEUE_POINTER <= l;
    SEND_QUEUE_POINTER <= s;
    {RX_FREE_BYTES, MESSAGE_LENGTH, TX_INCREMENT_BLOCKED} <= {f, m, b};
  endtask : set
  // one start request, then time for grant and line start to land
  task automatic kick();
    @(posedge CLK);
    go <= 1'b1;
    @(posedge CLK);
    go <= 1'b0;
    repeat (3) @(posedge CLK);
    #1;
  endtask : kick
  task automatic finish_test();
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : finish_test
  // watchdog at 2000 cycles; the whole sequence needs well under 200 cycles
  initial
  begin
    #20000;
    fails++;
    finish_test();
  end
  initial
  begin
    {ADDR, WDATA, WR, RD, RX_BYTE_WRITE, go} <= '0;
    {LOAD_QUEUE_POINTER, SEND_QUEUE_POINTER} <= '0;
    {RX_FREE_BYTES, MESSAGE_LENGTH} <= {9'h100, 9'h010};
    TX_INCREMENT_BLOCKED <= 1'b0;
    RST <= 1'b1;
    repeat (5) @(posedge CLK);
    RST <= 1'b0;
    rd(8'h02, 8'h13);
    set(3'h7, 3'h0, 9'h100, 9'h010, 1'b1);
    rd(8'h02, 8'h1C);
    set(3'h3, 3'h3, 9'h010, 9'h010, 1'b1);
    rd(8'h02, 8'h93);
    set(3'h3, 3'h3, 9'h011, 9'h010, 1'b0);
    rd(8'h02, 8'h13);
    set(3'h3, 3'h3, 9'h0FF, 9'h0FF, 1'b0);
    kick();
    chk("grant", 8'h00, {7'h0, START_GRANT});
    chk("sending", 8'h00, {7'h0, TX_SENDING});
    set(3'h3, 3'h3, 9'h100, 9'h0FF, 1'b0);
    repeat (2) @(posedge CLK);
    rd(8'h02, 8'h23);
    wr(8'h10, 8'h01);
    chk("ignore", 8'h01, {7'h0, IGNORE_RECEIVE_SPACE});
    rd(8'h10, 8'h01);
    set(3'h3, 3'h3, 9'h000, 9'h010, 1'b0);
    kick();
    chk("sending", 8'h01, {7'h0, TX_SENDING});
    rd(8'h02, 8'h23);
    wr(8'h11, 8'h1F);
    wr(8'h12, 8'h08);
    rd(8'h12, 8'h08);
    @(posedge CLK);
    RX_BYTE_WRITE <= 1'b1;
    @(posedge CLK);
    RX_BYTE_WRITE <= 1'b0;
    #1 chk("overflow", 8'h01, {7'h0, RECEIVE_OVERFLOW_ERROR});
    chk("irq", 8'h01, {7'h0, IRQ});
    rd(8'h13, 8'h01);
    rd(8'h11, 8'h08);
    set(3'h3, 3'h3, 9'h001, 9'h010, 1'b0);
    @(posedge CLK);
    #1 chk("overflow", 8'h00, {7'h0, RECEIVE_OVERFLOW_ERROR});
    wr(8'h11, 8'h08);
    chk("irq", 8'h00, {7'h0, IRQ});
    rd(8'h7F, 8'h00);
    finish_test();
  end
endmodule : uart_transmit_queue_status_bench
